/* serial_status_flags.sv */
/*
 * Status-flag logic of a serial unit: holding-register empty/full flags, receive
 * error flags, transmit complete and the multiprocessor bits, behind an AXI4-Lite
 * slave. Assumes the shifters outside raise one-cycle strobes on clk_i and hold
 * the frame fields valid with those strobes.
 */
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
// Functional notes
// - Writing 1 to the five clearable flags never sets them.
// - A 0 write clears a flag only after software read it as 1.
// - Transmit complete and received multiprocessor bit take no write data.
// - Reset and standby load the status register with 0x84.
// - Holding empty sets on shifter load, transmitter off, reset or standby.
// - Holding empty clears by read-then-write-0 or by a DMA holding write.
// - Receive full sets when an error-free frame enters the holding register.
// - Receive full clears on reset, standby, read-then-write-0, or DMA read.
// - Errors and receiver off leave holding data and receive full unchanged.
// - Frame ending while receive full is set raises overrun; new byte lost.
// - Error flags halt reception, and in synchronous mode transmission too.
// - Framing flag sets when first stop bit is 0 in asynchronous mode.
// - Framing or parity error still loads data but leaves receive full clear.
// - Parity flag sets when ones count mismatches the odd/even selection, in async non-multiprocessor mode.
// - Receiver off leaves the overrun, framing and parity flags unchanged.
// - Transmit complete sets if holding empty at last bit, transmitter off, reset.
// - Transmit complete clears whenever holding empty is cleared.
// - Received multiprocessor bit is captured in multiprocessor format, kept when off.
// - Outgoing multiprocessor bit is used only in async multiprocessor transmit.
`timescale 1ns/1ns
module serial_status_flags #(
    parameter int data_width = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic standby_i,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Shifter side.
    input wire logic tx_load_i,
    input wire logic tx_last_bit_i,
    input wire logic rx_done_i,
    input wire logic [data_width-1:0] rx_data_i,
    input wire logic rx_parity_i,
    input wire logic rx_stop_i,
    input wire logic rx_multiproc_i,
    // DMA side.
    input wire logic dma_tx_write_i,
    input wire logic [data_width-1:0] dma_tx_data_i,
    input wire logic dma_rx_read_i,
    output logic [data_width-1:0] rx_holding_reg_o,
    output logic [data_width-1:0] tx_holding_reg_o,
    output logic tx_holding_empty_o,
    output logic rx_enable_o,
    output logic tx_enable_o,
    output logic tx_multiproc_o,
    output logic receiver_on_o,
    output logic transmitter_on_o,
    output logic parity_odd_select_o
);

    logic [7:0] serial_status;
    logic [7:0] serial_control;
    logic [7:0] seen_set;
    logic [data_width-1:0] rx_holding_reg;
    logic [data_width-1:0] tx_holding_reg;
    logic init;
    logic receiver_on;
    logic transmitter_on;
    logic sync_mode;
    logic multiproc_mode;
    logic parity_odd;
    logic rx_error;
    logic rx_accept;
    logic frame_bad;
    logic parity_bad;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [7:0] w_data;
    logic w_lane0;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] next_status;
    logic [7:0] next_seen;
    logic [7:0] clear_req;
    logic wr_status;
    logic next_error;

    // Standby applies the same flag load as reset but leaves the bus and control alone.
    assign init = reset_i | standby_i;
    assign receiver_on = serial_control[serial_status_pkg::receiver_on_bit];
    assign transmitter_on = serial_control[serial_status_pkg::transmitter_on_bit];
    assign sync_mode = serial_control[serial_status_pkg::sync_mode_bit];
    assign multiproc_mode = serial_control[serial_status_pkg::multiproc_mode_bit];
    assign parity_odd = serial_control[serial_status_pkg::parity_odd_select_bit];
    assign rx_error = serial_status[serial_status_pkg::overrun_flag_bit]
        | serial_status[serial_status_pkg::framing_flag_bit]
        | serial_status[serial_status_pkg::parity_flag_bit];
    // A frame is only taken while the receiver runs and no error halts it.
    assign rx_accept = rx_done_i & receiver_on & ~rx_error;
    assign frame_bad = ~sync_mode & ~rx_stop_i;
    assign parity_bad = ~sync_mode & ~multiproc_mode
        & ((^rx_data_i ^ rx_parity_i) != parity_odd);

    // ------------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------------
    // Both halves of a write wait in holding flags until both are in; the readies stay low until the response is taken.
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid_o;
    assign wr_status = wr_fire & w_lane0 && aw_addr == serial_status_pkg::status_offset;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= serial_status_pkg::resp_okay;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i[7:0];
                w_lane0 <= s_axi_wstrb_i[0];
                s_axi_wready_o <= 1'b0;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (aw_addr[7:2] <= serial_status_pkg::control_offset[7:2])
                    ? serial_status_pkg::resp_okay : serial_status_pkg::resp_slverr;
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------------
    // The answer stands until rready, and arready stays low so no second read overlaps.
    assign rd_fire = s_axi_arvalid_i & s_axi_arready_o;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= serial_status_pkg::resp_okay;
        end else if (rd_fire) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= serial_status_pkg::resp_okay;
            unique case (s_axi_araddr_i)
                serial_status_pkg::status_offset: begin
                    s_axi_rdata_o <= {24'h000000, serial_status};
                end
                serial_status_pkg::holding_offset: begin
                    s_axi_rdata_o <= {16'h0000, 8'(tx_holding_reg), 8'(rx_holding_reg)};
                end
                serial_status_pkg::control_offset: begin
                    s_axi_rdata_o <= {24'h000000, serial_control};
                end
                default: begin
                    s_axi_rdata_o <= 32'h0000_0000;
                    s_axi_rresp_o <= serial_status_pkg::resp_slverr;
                end
            endcase
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Control and holding registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            serial_control <= serial_status_pkg::control_reset;
            tx_holding_reg <= '0;
        end else begin
            if (wr_fire && w_lane0 && aw_addr == serial_status_pkg::control_offset) begin
                serial_control <= w_data;
            end
            // A DMA load must never be lost to a bus write landing in the same cycle.
            if (dma_tx_write_i) begin
                tx_holding_reg <= dma_tx_data_i;
            end else if (wr_fire && w_lane0
                    && aw_addr == serial_status_pkg::holding_offset) begin
                tx_holding_reg <= data_width'(w_data);
            end
        end
    end

    // Errors and receiver off never touch the holding data; erroneous frames still land.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_holding_reg <= '0;
        end else if (rx_accept && !serial_status[serial_status_pkg::rx_holding_full_bit]) begin
            rx_holding_reg <= rx_data_i;
        end
    end

    // ------------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------------
    // A clear needs a 0 write to a bit that software has already seen set.
    assign clear_req = wr_status ? (~w_data & seen_set) : 8'h00;

    always_comb begin
        next_status = serial_status;
        next_seen = seen_set;
        if (rd_fire && s_axi_araddr_i == serial_status_pkg::status_offset) begin
            next_seen = seen_set | serial_status;
        end
        // Clearable flags: clears first so a same-cycle hardware set wins.
        for (int i = 3; i <= 7; i++) begin
            if (clear_req[i]) begin
                next_status[i] = 1'b0;
                next_seen[i] = 1'b0;
            end
        end
        if (clear_req[serial_status_pkg::tx_holding_empty_bit] || dma_tx_write_i) begin
            next_status[serial_status_pkg::tx_holding_empty_bit] = 1'b0;
            next_status[serial_status_pkg::tx_complete_bit] = 1'b0;
            next_seen[serial_status_pkg::tx_holding_empty_bit] = 1'b0;
        end
        if (dma_rx_read_i) begin
            next_status[serial_status_pkg::rx_holding_full_bit] = 1'b0;
            next_seen[serial_status_pkg::rx_holding_full_bit] = 1'b0;
        end
        if (tx_load_i || !transmitter_on) begin
            next_status[serial_status_pkg::tx_holding_empty_bit] = 1'b1;
        end
        if ((tx_last_bit_i && serial_status[serial_status_pkg::tx_holding_empty_bit])
                || !transmitter_on) begin
            next_status[serial_status_pkg::tx_complete_bit] = 1'b1;
        end
        if (rx_accept) begin
            if (serial_status[serial_status_pkg::rx_holding_full_bit]) begin
                next_status[serial_status_pkg::overrun_flag_bit] = 1'b1;
            end else begin
                if (frame_bad) begin
                    next_status[serial_status_pkg::framing_flag_bit] = 1'b1;
                end
                if (parity_bad) begin
                    next_status[serial_status_pkg::parity_flag_bit] = 1'b1;
                end
                if (!frame_bad && !parity_bad) begin
                    next_status[serial_status_pkg::rx_holding_full_bit] = 1'b1;
                end
                if (multiproc_mode && !sync_mode) begin
                    next_status[serial_status_pkg::rx_multiproc_bit_pos] = rx_multiproc_i;
                end
            end
        end
        // Transmit complete and the received multiprocessor bit take no write data.
        if (wr_status) begin
            next_status[serial_status_pkg::tx_multiproc_bit_pos] =
                w_data[serial_status_pkg::tx_multiproc_bit_pos];
        end
        // Standby reloads the flags in the cycle it is asserted; next_status carries
        // that load so the registered outputs follow on the same edge as the register.
        if (standby_i) begin
            next_status = serial_status_pkg::status_reset;
            next_seen = 8'h00;
        end
    end

    // Receiver off only gates rx_accept, so error flags hold their values.
    always_ff @(posedge clk_i) begin
        if (init) begin
            serial_status <= serial_status_pkg::status_reset;
            seen_set <= 8'h00;
        end else begin
            serial_status <= next_status;
            seen_set <= next_seen;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs to shifters and DMA
    // ------------------------------------------------------------------------
    // Every output is registered; error flags are taken as they stand after this edge
    // so that the enables drop on the same edge as the flag rises.
    assign next_error = next_status[serial_status_pkg::overrun_flag_bit]
        | next_status[serial_status_pkg::framing_flag_bit]
        | next_status[serial_status_pkg::parity_flag_bit];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rx_holding_reg_o <= '0;
            tx_holding_reg_o <= '0;
            tx_holding_empty_o <= 1'b1;
            rx_enable_o <= 1'b0;
            tx_enable_o <= 1'b0;
            tx_multiproc_o <= 1'b0;
            receiver_on_o <= 1'b0;
            transmitter_on_o <= 1'b0;
            parity_odd_select_o <= 1'b0;
        end else begin
            rx_holding_reg_o <= rx_holding_reg;
            tx_holding_reg_o <= tx_holding_reg;
            tx_holding_empty_o <= next_status[serial_status_pkg::tx_holding_empty_bit];
            rx_enable_o <= receiver_on & ~next_error;
            tx_enable_o <= transmitter_on & ~(sync_mode & next_error);
            tx_multiproc_o <= ~sync_mode & multiproc_mode & transmitter_on
                & next_status[serial_status_pkg::tx_multiproc_bit_pos];
            receiver_on_o <= receiver_on;
            transmitter_on_o <= transmitter_on;
            parity_odd_select_o <= parity_odd;
        end
    end

endmodule

/* serial_status_pkg.sv */
/*
 * Constants for the serial status-flag block: register offsets, bit positions,
 * reset values and bus response codes.
 * Assumes a single 25 MHz clock and an AXI4-Lite register bus with 32-bit data.
 */
package serial_status_pkg;

    // ------------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------------
    localparam logic [7:0] status_offset = 8'h00;
    localparam logic [7:0] holding_offset = 8'h04;
    localparam logic [7:0] control_offset = 8'h08;

    // ------------------------------------------------------------------------
    // Status bit positions and reset value
    // ------------------------------------------------------------------------
    localparam int tx_holding_empty_bit = 7;
    localparam int rx_holding_full_bit = 6;
    localparam int overrun_flag_bit = 5;
    localparam int framing_flag_bit = 4;
    localparam int parity_flag_bit = 3;
    localparam int tx_complete_bit = 2;
    localparam int rx_multiproc_bit_pos = 1;
    localparam int tx_multiproc_bit_pos = 0;
    localparam logic [7:0] status_reset = 8'h84;

    // ------------------------------------------------------------------------
    // Control register fields (receiver_on, transmitter_on, modes)
    // ------------------------------------------------------------------------
    localparam int receiver_on_bit = 0;
    localparam int transmitter_on_bit = 1;
    localparam int sync_mode_bit = 2;
    localparam int multiproc_mode_bit = 3;
    localparam int parity_odd_select_bit = 4;
    localparam logic [7:0] control_reset = 8'h00;

    // ------------------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------------------
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

endpackage

/* shifter_model.sv */
/*
 * Model of the shifters and the DMA unit beside the status block.
 * Assumes the caller enters each task right after a rising edge of clk_i.
 */
`timescale 1ns/1ns
module shifter_model (
    input wire logic clk_i,
    output logic rx_done_o,
    output logic [7:0] rx_data_o,
    output logic rx_parity_o,
    output logic rx_stop_o,
    output logic rx_multiproc_o,
    output logic tx_load_o,
    output logic tx_last_bit_o,
    output logic dma_tx_write_o,
    output logic [7:0] dma_tx_data_o,
    output logic dma_rx_read_o
);
    initial begin
        {rx_done_o, rx_data_o, rx_parity_o, rx_stop_o, rx_multiproc_o} = '0;
        {tx_load_o, tx_last_bit_o, dma_tx_write_o, dma_tx_data_o, dma_rx_read_o} = '0;
    end

    // Only the first stop bit is offered, so the field lines go stale after the strobe.
    task automatic frame(input logic [7:0] d, input logic p, input logic s, input logic m);
        rx_data_o <= d;
        rx_parity_o <= p;
        rx_stop_o <= s;
        rx_multiproc_o <= m;
        rx_done_o <= 1'b1;
        @(posedge clk_i);
        rx_done_o <= 1'b0;
        rx_data_o <= ~d;
        rx_parity_o <= ~p;
        rx_stop_o <= ~s;
        rx_multiproc_o <= ~m;
        @(posedge clk_i);
    endtask

    // Strobe 0 loads the shifter, 1 ends a character, 2 is a DMA read, 3 a DMA write.
    task automatic strobe(input int which, input logic [7:0] d);
        tx_load_o <= (which == 0);
        tx_last_bit_o <= (which == 1);
        dma_rx_read_o <= (which == 2);
        dma_tx_write_o <= (which == 3);
        dma_tx_data_o <= d;
        @(posedge clk_i);
        {tx_load_o, tx_last_bit_o, dma_rx_read_o, dma_tx_write_o} <= 4'h0;
        dma_tx_data_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule

/* serial_status_flags_properties.sv */
/*
 * Concurrent checks on the ports of the serial status-flag block.
 * Assumes it is bound into serial_status_flags and sees only its ports.
 */
`timescale 1ns/1ns
module serial_status_flags_checker #(
    parameter int data_width = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic standby_i,
    input wire logic tx_load_i,
    input wire logic dma_tx_write_i,
    input wire logic [data_width-1:0] dma_tx_data_i,
    input wire logic transmitter_on_o,
    input wire logic receiver_on_o,
    input wire logic tx_holding_empty_o,
    input wire logic [data_width-1:0] tx_holding_reg_o,
    input wire logic tx_multiproc_o,
    input wire logic rx_enable_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // The empty output is a registered copy, so set and clear get up to two edges.
    chk_reset_empty: assert property ($past(reset_i) |-> tx_holding_empty_o)
        else $error("holding empty low after reset");
    chk_standby_init: assert property (standby_i |-> ##[1:2] tx_holding_empty_o)
        else $error("standby did not set holding empty");
    chk_load_sets: assert property (tx_load_i |-> ##[1:2] tx_holding_empty_o)
        else $error("shifter load did not set holding empty");
    chk_txoff_empty: assert property (!transmitter_on_o [*3] |-> tx_holding_empty_o)
        else $error("holding empty low with transmitter off");
    chk_dma_clears: assert property (dma_tx_write_i && !tx_load_i && transmitter_on_o
        && !standby_i |-> ##[1:2] !tx_holding_empty_o)
        else $error("DMA write did not clear holding empty");
    chk_dma_data: assert property (dma_tx_write_i |-> ##2
        tx_holding_reg_o == $past(dma_tx_data_i, 2))
        else $error("DMA data not in transmit holding");
    chk_rx_gate: assert property (rx_enable_o |-> receiver_on_o || $past(receiver_on_o))
        else $error("receive enabled with receiver off");
    chk_mp_gate: assert property (tx_multiproc_o
        |-> transmitter_on_o || $past(transmitter_on_o))
        else $error("multiprocessor bit sent with transmitter off");
    chk_write_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
        else $error("write address accepted during response");
    chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    chk_read_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read address accepted during response");

    cov_standby: cover property (standby_i);
    cov_dma_write: cover property (dma_tx_write_i);
    cov_mp_out: cover property (tx_multiproc_o);
endmodule

bind serial_status_flags serial_status_flags_checker #(.data_width(data_width)) i_chk (.*);

/* tb_top.sv */
/*
 * Self-checking bench for the serial status-flag block.
 * Assumes the shifter model drives the frame and DMA strobes.
 */
`timescale 1ns/1ns
module tb_top;
    logic clk_i = 0, reset_i = 1, standby_i = 0;
    logic [7:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
    logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, rd;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
    logic s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rr, br;
    logic rx_done_i, rx_parity_i, rx_stop_i, rx_multiproc_i, tx_load_i, tx_last_bit_i;
    logic dma_tx_write_i, dma_rx_read_i;
    logic [7:0] rx_data_i, dma_tx_data_i, rx_holding_reg_o, tx_holding_reg_o;
    logic tx_holding_empty_o, rx_enable_o, tx_enable_o, tx_multiproc_o;
    logic receiver_on_o, transmitter_on_o, parity_odd_select_o;
    int bad_count = 0, num_checks = 0;

    serial_status_flags i_dut (.*);
    shifter_model i_model (.clk_i(clk_i), .rx_done_o(rx_done_i), .rx_data_o(rx_data_i),
        .rx_parity_o(rx_parity_i), .rx_stop_o(rx_stop_i), .rx_multiproc_o(rx_multiproc_i),
        .tx_load_o(tx_load_i), .tx_last_bit_o(tx_last_bit_i), .dma_tx_write_o(dma_tx_write_i),
        .dma_tx_data_o(dma_tx_data_i), .dma_rx_read_o(dma_rx_read_i));

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hang();
        bad_count++;
        $display("CHECK FAILED %0t bus answer missing", $time);
        complete_run();
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic done;
        done = 0;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        for (n = 0; n < 40 && !done; n++) begin
            @(posedge clk_i);
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            done = s_axi_bvalid_o;
            br = s_axi_bresp_o;
        end
        if (!done) hang();
    endtask

    task automatic bus_read(input logic [7:0] a);
        int n;
        logic done;
        done = 0;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        for (n = 0; n < 40 && !done; n++) begin
            @(posedge clk_i);
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            done = s_axi_rvalid_o;
            rd = s_axi_rdata_o;
            rr = s_axi_rresp_o;
        end
        if (!done) hang();
    endtask

    // Reading the status also arms the clear of every clearable flag seen as one.
    task automatic check_status(input logic [7:0] exp);
        bus_read(serial_status_pkg::status_offset);
        cmp_val(rd, {24'h0, exp});
    endtask

    task automatic wr_status(input logic [7:0] d, input logic [7:0] exp);
        bus_write(serial_status_pkg::status_offset, {24'h0, d});
        check_status(exp);
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        check_status(8'h84);
        bus_read(8'h0c);
        cmp_val(rd, 32'h0);
        cmp_val({30'h0, rr}, {30'h0, serial_status_pkg::resp_slverr});
        bus_write(8'h0c, 32'hff);
        cmp_val({30'h0, br}, {30'h0, serial_status_pkg::resp_slverr});
        bus_write(serial_status_pkg::control_offset, 32'h03);
        cmp_val({30'h0, br}, {30'h0, serial_status_pkg::resp_okay});
        standby_i <= 1'b1;
        @(posedge clk_i);
        standby_i <= 1'b0;
        @(posedge clk_i);
        wr_status(8'h00, 8'h84);
        wr_status(8'hff, 8'h85);
        wr_status(8'h00, 8'h00);
        i_model.strobe(0, 8'h00);
        check_status(8'h80);
        i_model.strobe(1, 8'h00);
        check_status(8'h84);
        i_model.strobe(3, 8'ha5);
        check_status(8'h00);
        i_model.frame(8'h3c, 1'b0, 1'b1, 1'b0);
        check_status(8'h40);
        i_model.frame(8'h55, 1'b0, 1'b1, 1'b0);
        check_status(8'h60);
        cmp_val({31'h0, rx_enable_o}, 32'h0);
        bus_read(serial_status_pkg::holding_offset);
        cmp_val(rd, 32'ha53c);
        wr_status(8'h00, 8'h00);
        i_model.frame(8'h11, 1'b0, 1'b0, 1'b0);
        check_status(8'h10);
        bus_read(serial_status_pkg::holding_offset);
        cmp_val(rd, 32'ha511);
        wr_status(8'h00, 8'h00);
        i_model.frame(8'h01, 1'b0, 1'b1, 1'b0);
        check_status(8'h08);
        bus_write(serial_status_pkg::control_offset, 32'h02);
        check_status(8'h08);
        bus_write(serial_status_pkg::control_offset, 32'h03);
        wr_status(8'h00, 8'h00);
        i_model.frame(8'h3c, 1'b0, 1'b1, 1'b0);
        i_model.strobe(2, 8'h00);
        check_status(8'h00);
        bus_write(serial_status_pkg::control_offset, 32'h13);
        i_model.frame(8'h01, 1'b0, 1'b1, 1'b0);
        cmp_val({31'h0, parity_odd_select_o}, 32'h1);
        check_status(8'h40);
        i_model.strobe(2, 8'h00);
        bus_write(serial_status_pkg::control_offset, 32'h0b);
        i_model.frame(8'h7e, 1'b0, 1'b1, 1'b1);
        check_status(8'h42);
        wr_status(8'h01, 8'h03);
        cmp_val({31'h0, tx_multiproc_o}, 32'h1);
        bus_write(serial_status_pkg::control_offset, 32'h09);
        check_status(8'h87);
        bus_write(serial_status_pkg::control_offset, 32'h07);
        i_model.frame(8'h00, 1'b1, 1'b0, 1'b0);
        cmp_val({31'h0, tx_enable_o}, 32'h1);
        i_model.frame(8'h00, 1'b1, 1'b0, 1'b0);
        cmp_val({31'h0, tx_enable_o}, 32'h0);
        check_status(8'he7);
        complete_run();
    end
endmodule
